// File: logic/udtap_defines.svh
// Constants of the user debug interface: command codes, capture values, levels.
// Assumes inclusion by bare name from the package; the top module has no include of its own.
`ifndef UDTAP_DEFINES_SVH
`define UDTAP_DEFINES_SVH

// ****************************************
// Widths
// ****************************************
`define UDTAP_IR_W 4

// ****************************************
// Command codes of the command register
// ****************************************
`define UDTAP_CMD_EXTEST 4'h0
`define UDTAP_CMD_WAKE 4'h1
`define UDTAP_CMD_SAMPLE 4'h4
`define UDTAP_CMD_IRQ 4'h5
`define UDTAP_CMD_RST_ASSERT 4'h6
`define UDTAP_CMD_RST_NEGATE 4'h7
`define UDTAP_CMD_BYPASS 4'hf

// ****************************************
// Fixed values
// ****************************************
`define UDTAP_IR_CAPTURE 4'h1
`define UDTAP_IRQ_LEVEL 4'hf

`endif

// File: logic/udtap_pkg.sv
// Types of the user debug interface: access port states and the pin bundle.
// Assumes udtap_defines.svh is on the include path.
`include "udtap_defines.svh"

package udtap_pkg;

  // ****************************************
  // Access port controller states
  // ****************************************
  typedef enum logic [3:0] {
    UDTAP_TLR,
    UDTAP_RTI,
    UDTAP_SEL_DR,
    UDTAP_CAP_DR,
    UDTAP_SH_DR,
    UDTAP_EX1_DR,
    UDTAP_PA_DR,
    UDTAP_EX2_DR,
    UDTAP_UPD_DR,
    UDTAP_SEL_IR,
    UDTAP_CAP_IR,
    UDTAP_SH_IR,
    UDTAP_EX1_IR,
    UDTAP_PA_IR,
    UDTAP_EX2_IR,
    UDTAP_UPD_IR
  } udtap_tap_t;

  // ****************************************
  // Pins from outside the clock domain
  // ****************************************
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic por_n;
    logic emu_sel;
  } udtap_pins_t;

endpackage : udtap_pkg

// File: logic/udtap.sv
// User debug interface: access port controller, command register, reset
// configuration and boundary scan cells.
// Assumes the link, reset, mode select and chain input pins are asynchronous to clk_i and the test clock is much slower.
`timescale 1ns/1ps

module udtap
  import udtap_pkg::*;
#(
  parameter int N_IN = 8,
  parameter int N_OUT = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic emulator_mode_select_i,
  input wire logic power_on_reset_pin_n_i,
  input wire logic emulator_break_mode_i,
  input wire logic boot_request_i,
  input wire logic sleep_mode_i,
  input wire logic standby_mode_i,
  output logic chip_reset_o,
  output logic debug_reset_o,
  output logic cpu_hold_o,
  output logic debug_irq_o,
  output logic [3:0] debug_irq_level_o,
  output logic wakeup_o,
  input wire logic [N_IN-1:0] pin_in_i,
  output logic [N_IN-1:0] core_in_o,
  input wire logic [N_OUT-1:0] core_out_i,
  output logic [N_OUT-1:0] pin_out_o
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (N_IN < 1 || N_OUT < 1) begin : g_bad_len
    $error("udtap: both cell counts must be at least one");
  end
  if (`UDTAP_IR_W != 4) begin : g_bad_irw
    $error("udtap: command codes are four bits wide");
  end

  localparam int LEN = N_IN + N_OUT;
  localparam int IRW = `UDTAP_IR_W;

  // ****************************************
  // State
  // ****************************************
  // Chain order: output cells at the top, input cells at the bottom, so the
  // input cells leave first on the serial output.
  typedef struct packed {
    udtap_pins_t s1;
    udtap_pins_t s2;
    logic tck_d;
    logic [N_IN-1:0] p1;
    logic [N_IN-1:0] p2;
    udtap_tap_t tap;
    logic tdi_s;
    logic shift_pend;
    logic [IRW-1:0] ir_sh;
    logic [IRW-1:0] cmd;
    logic byp;
    logic [LEN-1:0] bsr;
    logic [N_OUT-1:0] olat;
    logic tdo;
    logic tdo_oe;
    logic udi_rst;
    logic hold;
    logic por_prev;
    logic chip_rst;
    logic irq;
    logic wake;
    logic [N_IN-1:0] core_in;
    logic [N_OUT-1:0] pin_out;
  } udtap_st_t;

  udtap_st_t q;
  udtap_st_t d;

  // ****************************************
  // Access port next state
  // ****************************************
  function automatic udtap_tap_t udtap_next(input udtap_tap_t s, input logic tms);
    udtap_tap_t n;
    n = s;
    case (s)
      UDTAP_TLR: n = tms ? UDTAP_TLR : UDTAP_RTI;
      UDTAP_RTI: n = tms ? UDTAP_SEL_DR : UDTAP_RTI;
      UDTAP_SEL_DR: n = tms ? UDTAP_SEL_IR : UDTAP_CAP_DR;
      UDTAP_CAP_DR: n = tms ? UDTAP_EX1_DR : UDTAP_SH_DR;
      UDTAP_SH_DR: n = tms ? UDTAP_EX1_DR : UDTAP_SH_DR;
      UDTAP_EX1_DR: n = tms ? UDTAP_UPD_DR : UDTAP_PA_DR;
      UDTAP_PA_DR: n = tms ? UDTAP_EX2_DR : UDTAP_PA_DR;
      UDTAP_EX2_DR: n = tms ? UDTAP_UPD_DR : UDTAP_SH_DR;
      UDTAP_UPD_DR: n = tms ? UDTAP_SEL_DR : UDTAP_RTI;
      UDTAP_SEL_IR: n = tms ? UDTAP_TLR : UDTAP_CAP_IR;
      UDTAP_CAP_IR: n = tms ? UDTAP_EX1_IR : UDTAP_SH_IR;
      UDTAP_SH_IR: n = tms ? UDTAP_EX1_IR : UDTAP_SH_IR;
      UDTAP_EX1_IR: n = tms ? UDTAP_UPD_IR : UDTAP_PA_IR;
      UDTAP_PA_IR: n = tms ? UDTAP_EX2_IR : UDTAP_PA_IR;
      UDTAP_EX2_IR: n = tms ? UDTAP_UPD_IR : UDTAP_SH_IR;
      UDTAP_UPD_IR: n = tms ? UDTAP_SEL_DR : UDTAP_RTI;
      default: n = UDTAP_TLR;
    endcase
    return n;
  endfunction : udtap_next

  // ****************************************
  // Next-state logic
  // ****************************************
  logic rise;
  logic fall;
  logic bsr_sel;
  logic in_sh_ir;
  logic emu;
  logic por_low;
  logic trst_low;
  logic por_fall;
  logic sh_ir;
  logic brk_mask;

  always_comb begin
    d = q;
    rise = q.s2.tck & ~q.tck_d;
    fall = ~q.s2.tck & q.tck_d;
    bsr_sel = (q.cmd == `UDTAP_CMD_SAMPLE) || (q.cmd == `UDTAP_CMD_EXTEST);
    in_sh_ir = (q.tap == UDTAP_SH_IR);
    emu = ~q.s2.emu_sel;
    por_low = ~q.s2.por_n;
    trst_low = ~q.s2.trst_n;
    por_fall = q.por_prev & ~q.s2.por_n;
    // The last shift bit lands after the move to Exit1, so the target is
    // taken from the Shift and Exit1 pair rather than from Shift alone
    sh_ir = (q.tap == UDTAP_SH_IR) || (q.tap == UDTAP_EX1_IR);
    brk_mask = emu & emulator_break_mode_i;

    // Two-stage synchronisers; stage one feeds stage two only
    // A test clock phase shorter than one system clock can be missed
    d.s1.tck = tck_i;
    d.s1.tms = tms_i;
    d.s1.tdi = tdi_i;
    d.s1.trst_n = trst_n_i;
    d.s1.por_n = power_on_reset_pin_n_i;
    d.s1.emu_sel = emulator_mode_select_i;
    d.s2 = q.s1;
    d.tck_d = q.s2.tck;
    d.p1 = pin_in_i;
    d.p2 = q.p1;
    d.irq = 1'b0;
    d.wake = 1'b0;

    // ****************************************
    // Rising test clock: move, sample, capture
    // ****************************************
    if (rise) begin
      d.tap = udtap_next(q.tap, q.s2.tms);
      d.tdi_s = q.s2.tdi;
      d.shift_pend = (q.tap == UDTAP_SH_DR) || in_sh_ir;
      if (q.tap == UDTAP_CAP_IR) begin
        d.ir_sh = `UDTAP_IR_CAPTURE;
      end
      if (q.tap == UDTAP_CAP_DR) begin
        if (bsr_sel) begin
          // Output cells take the core value even under external test; it is
          // shifted over before use
          d.bsr = {core_out_i, q.p2};
        end else begin
          d.byp = 1'b0;
        end
      end
    end

    // ****************************************
    // Falling test clock: shift, drive, update
    // ****************************************
    if (fall) begin
      if (q.shift_pend) begin
        if (sh_ir) begin
          d.ir_sh = {q.tdi_s, q.ir_sh[IRW-1:1]};
        end else if (bsr_sel) begin
          d.bsr = {q.tdi_s, q.bsr[LEN-1:1]};
        end else begin
          d.byp = q.tdi_s;
        end
        d.shift_pend = 1'b0;
      end
      // Exit1 after the last shift drops the enable, so the pin floats there
      d.tdo_oe = (q.tap == UDTAP_SH_DR) || in_sh_ir;
      if (in_sh_ir) begin
        d.tdo = d.ir_sh[0];
      end else if (bsr_sel) begin
        d.tdo = d.bsr[0];
      end else begin
        d.tdo = d.byp;
      end
      if (q.tap == UDTAP_UPD_DR && bsr_sel) begin
        d.olat = q.bsr[LEN-1 -: N_OUT];
      end
      // Standby freezes the core, so a command loaded then would be lost anyway
      if (q.tap == UDTAP_UPD_IR && !standby_mode_i) begin
        d.cmd = q.ir_sh;
        case (q.ir_sh)
          `UDTAP_CMD_RST_ASSERT: d.udi_rst = 1'b1;
          `UDTAP_CMD_RST_NEGATE: d.udi_rst = 1'b0;
          `UDTAP_CMD_IRQ: begin
            d.irq = ~sleep_mode_i;
            d.cmd = `UDTAP_CMD_BYPASS;
          end
          `UDTAP_CMD_WAKE: d.wake = sleep_mode_i;
          default: d.cmd = q.ir_sh;
        endcase
      end
    end

    if (q.tap == UDTAP_TLR) begin
      d.cmd = `UDTAP_CMD_BYPASS;
    end
    // Test reset wins over any test clock activity
    if (trst_low) begin
      d.tap = UDTAP_TLR;
      d.shift_pend = 1'b0;
      d.tdo_oe = 1'b0;
      d.udi_rst = 1'b0;
    end

    // ****************************************
    // Reset configuration
    // ****************************************
    d.por_prev = q.s2.por_n;
    // A new hold request wins over a boot request in the same cycle
    if (emu && por_low && trst_low) begin
      d.hold = 1'b1;
    end else if (boot_request_i || por_fall) begin
      d.hold = 1'b0;
    end
    d.chip_rst = (por_low & ~brk_mask) | q.udi_rst;

    // ****************************************
    // Pin paths
    // ****************************************
    d.core_in = q.p2;
    d.pin_out = (q.cmd == `UDTAP_CMD_EXTEST) ? q.olat : core_out_i;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.cmd <= `UDTAP_CMD_BYPASS;
      q.s1.trst_n <= 1'b1;
      q.s2.trst_n <= 1'b1;
      q.s1.por_n <= 1'b1;
      q.s2.por_n <= 1'b1;
      q.s1.emu_sel <= 1'b1;
      q.s2.emu_sel <= 1'b1;
      q.por_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Chain cells model the pin_in_i and core_out_i pins only; clock, reset and access port
  // pins never enter the chain
  assign core_in_o = q.core_in;
  assign pin_out_o = q.pin_out;
  assign tdo_o = q.tdo;
  assign tdo_oe_o = q.tdo_oe;
  assign chip_reset_o = q.chip_rst;
  assign debug_reset_o = ~q.s2.trst_n;
  assign cpu_hold_o = q.hold;
  assign debug_irq_o = q.irq;
  assign debug_irq_level_o = `UDTAP_IRQ_LEVEL;
  assign wakeup_o = q.wake;

endmodule : udtap

// File: verif/udtap_asserts.sv
// Port checker of the user debug interface.
// Assumes it is bound to udtap and that the test link runs far slower than clk_i.
`timescale 1ns/1ps
module udtap_asserts #(parameter int N_IN = 8, parameter int N_OUT = 8) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic emulator_mode_select_i,
  input wire logic power_on_reset_pin_n_i,
  input wire logic boot_request_i,
  input wire logic sleep_mode_i,
  input wire logic standby_mode_i,
  input wire logic chip_reset_o,
  input wire logic debug_reset_o,
  input wire logic cpu_hold_o,
  input wire logic debug_irq_o,
  input wire logic [3:0] debug_irq_level_o,
  input wire logic wakeup_o,
  input wire logic [N_IN-1:0] pin_in_i,
  input wire logic [N_IN-1:0] core_in_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  irq_level_a: assert property (debug_irq_level_o == 4'hf)
    else $error("irq level not 15");
  tdo_edge_a: assert property ($changed(tdo_o) |-> !tck_i && $past(tck_i, 2) == 1'b0)
    else $error("tdo moved outside a low test clock phase");
  oe_rise_a: assert property ($rose(tdo_oe_o) |-> !tck_i)
    else $error("tdo enable rose outside a low phase");
  trst_low_a: assert property (!trst_n_i [*5] |-> debug_reset_o && !tdo_oe_o)
    else $error("test reset not applied");
  trst_high_a: assert property (trst_n_i [*5] |-> !debug_reset_o)
    else $error("debug reset without test reset");
  por_reset_a: assert property ((emulator_mode_select_i && !power_on_reset_pin_n_i) [*5]
    |-> chip_reset_o) else $error("power-on reset not passed");
  hold_set_a: assert property ((!emulator_mode_select_i && !power_on_reset_pin_n_i &&
    !trst_n_i) [*5] |-> cpu_hold_o) else $error("reset hold not entered");
  hold_end_a: assert property ($fell(cpu_hold_o) |-> $past(boot_request_i) ||
    $past(boot_request_i, 2) || !power_on_reset_pin_n_i) else $error("hold left early");
  irq_once_a: assert property (debug_irq_o |-> !(sleep_mode_i || standby_mode_i)
    ##1 !debug_irq_o) else $error("irq refused case or pulse length");
  wake_once_a: assert property (wakeup_o |-> sleep_mode_i ##1 !wakeup_o)
    else $error("wake pulse wrong");
  pin_pass_a: assert property ($stable(pin_in_i) [*4] |-> core_in_o == pin_in_i)
    else $error("pins not passed to core");
endmodule : udtap_asserts

bind udtap udtap_asserts #(.N_IN(N_IN), .N_OUT(N_OUT)) u_asserts (.clk_i(clk_i),
  .nrst_i(nrst_i), .tck_i(tck_i), .trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .emulator_mode_select_i(emulator_mode_select_i),
  .power_on_reset_pin_n_i(power_on_reset_pin_n_i), .boot_request_i(boot_request_i),
  .sleep_mode_i(sleep_mode_i), .standby_mode_i(standby_mode_i), .chip_reset_o(chip_reset_o),
  .debug_reset_o(debug_reset_o), .cpu_hold_o(cpu_hold_o), .debug_irq_o(debug_irq_o),
  .debug_irq_level_o(debug_irq_level_o), .wakeup_o(wakeup_o), .pin_in_i(pin_in_i),
  .core_in_o(core_in_o));

// File: verif/udtap_host.sv
// Host model of the test link: test clock, mode select, serial input, test reset.
// Assumes an 80 ns test clock that stands still low between frames.
`timescale 1ns/1ps
module udtap_host (
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b1;
  end
  // Inputs settle in the low phase; tdo is read just before the rise
  task automatic cyc(input logic m, input logic d, output logic o);
    tms_o = m;
    tdi_o = d;
    #40;
    o = tdo_i;
    tck_o = 1'b1;
    #40;
    tck_o = 1'b0;
  endtask : cyc
  // Outside a shift the serial input flips so stale data never looks valid
  task automatic mv(input logic m);
    logic o;
    cyc(m, ~tdi_o, o);
  endtask : mv
  task automatic tlr();
    #3;
    repeat (5) mv(1'b1);
    mv(1'b0);
  endtask : tlr
  // From Run-Test-Idle through one scan, LSB first, back to Run-Test-Idle
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    logic o;
    #3;
    dout = 16'h0000;
    mv(1'b1);
    if (ir)
      mv(1'b1);
    mv(1'b0);
    mv(1'b0);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], o);
      dout[i] = o;
    end
    mv(1'b1);
    mv(1'b0);
  endtask : scan
  task automatic trst(input logic v);
    trst_n_o <= v;
  endtask : trst
endmodule : udtap_host

// File: verif/udtap_tb_top.sv
// Self-checking bench of the user debug interface with a host model on the link.
// Assumes the checker and host model are compiled first.
`timescale 1ns/1ps
module udtap_tb_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, chip_rst, dbg_rst, hold, irq, wake;
  logic emu, por_n, brk, boot, slp, stby;
  logic tdo_pin;
  logic [3:0] lvl;
  logic [7:0] pin_in, core_in, core_out, pin_out;
  logic [15:0] d;
  int err_total = 0;
  int comparisons = 0;
  int irq_n = 0;
  int wake_n = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (irq === 1'b1) irq_n <= irq_n + 1;
  always @(posedge clk_i) if (wake === 1'b1) wake_n <= wake_n + 1;
  udtap dut (.clk_i(clk_i), .nrst_i(nrst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .emulator_mode_select_i(emu),
    .power_on_reset_pin_n_i(por_n), .emulator_break_mode_i(brk), .boot_request_i(boot),
    .sleep_mode_i(slp), .standby_mode_i(stby), .chip_reset_o(chip_rst),
    .debug_reset_o(dbg_rst), .cpu_hold_o(hold), .debug_irq_o(irq), .debug_irq_level_o(lvl),
    .wakeup_o(wake), .pin_in_i(pin_in), .core_in_o(core_in), .core_out_i(core_out),
    .pin_out_o(pin_out));
  // Pull-up on the released serial output, so a missing enable reads as ones
  assign tdo_pin = tdo_oe ? tdo : 1'b1;
  udtap_host p (.tdo_i(tdo_pin), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask : w
  // The access port keeps running in every mode, so the capture value always shows
  task automatic ir(input logic [3:0] c);
    p.scan(1'b1, 4, {12'h000, c}, d);
    chk(d, 16'h0001);
    w(8);
  endtask : ir
  task automatic t_bypass();
    chk(lvl, 4'hf);
    p.tlr();
    p.scan(1'b0, 4, 16'h000b, d);
    chk(d, 16'h0006);
    $display("test bypass done");
  endtask : t_bypass
  task automatic t_scan();
    pin_in <= 8'ha5;
    core_out <= 8'h3c;
    por_n <= 1'b0;
    emu <= 1'b0;
    ir(4'h4);
    chk(pin_out, 8'h3c);
    chk(core_in, 8'ha5);
    p.scan(1'b0, 16, 16'h96e1, d);
    chk(d, 16'h3ca5);
    ir(4'h0);
    chk(pin_out, 8'h96);
    p.scan(1'b0, 16, 16'h5a00, d);
    chk(d[7:0], 8'ha5);
    w(8);
    chk(pin_out, 8'h5a);
    ir(4'hf);
    chk(pin_out, 8'h3c);
    por_n <= 1'b1;
    emu <= 1'b1;
    $display("test scan done");
  endtask : t_scan
  task automatic t_cmds();
    ir(4'h6);
    chk(chip_rst, 1'b1);
    p.scan(1'b0, 4, 16'h0003, d);
    chk(chip_rst, 1'b1);
    ir(4'h7);
    chk(chip_rst, 1'b0);
    ir(4'h5);
    chk(16'(irq_n), 16'h0001);
    slp <= 1'b1;
    ir(4'h5);
    ir(4'h1);
    chk(16'(wake_n), 16'h0001);
    slp <= 1'b0;
    stby <= 1'b1;
    ir(4'h5);
    ir(4'h6);
    chk(16'(irq_n), 16'h0001);
    chk(chip_rst, 1'b0);
    stby <= 1'b0;
    $display("test commands done");
  endtask : t_cmds
  task automatic t_resets();
    por_n <= 1'b0;
    w(8);
    chk({chip_rst, dbg_rst}, 2'h2);
    por_n <= 1'b1;
    p.trst(1'b0);
    w(8);
    chk({chip_rst, dbg_rst, tdo_oe}, 3'h2);
    p.trst(1'b1);
    emu <= 1'b0;
    brk <= 1'b1;
    por_n <= 1'b0;
    w(8);
    chk(chip_rst, 1'b0);
    brk <= 1'b0;
    w(8);
    chk(chip_rst, 1'b1);
    p.trst(1'b0);
    w(8);
    por_n <= 1'b1;
    p.trst(1'b1);
    w(8);
    chk(hold, 1'b1);
    boot <= 1'b1;
    w(1);
    boot <= 1'b0;
    w(4);
    chk(hold, 1'b0);
    p.trst(1'b0);
    por_n <= 1'b0;
    w(8);
    p.trst(1'b1);
    por_n <= 1'b1;
    w(8);
    por_n <= 1'b0;
    w(8);
    chk(hold, 1'b0);
    por_n <= 1'b1;
    emu <= 1'b1;
    w(8);
    $display("test resets done");
  endtask : t_resets
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  // A hung scan cannot stall the run past this limit
  initial begin
    #500us;
    err_total++;
    end_sim();
  end
  initial begin
    emu <= 1'b1;
    por_n <= 1'b1;
    brk <= 1'b0;
    boot <= 1'b0;
    slp <= 1'b0;
    stby <= 1'b0;
    pin_in <= 8'h00;
    core_out <= 8'h00;
    w(12);
    nrst_i <= 1'b1;
    w(4);
    t_bypass();
    t_scan();
    t_cmds();
    t_resets();
    end_sim();
  end
endmodule : udtap_tb_top
